// *** bench/rore_exec_assertions.sv ***
// Port checker for the exec block
`timescale 1ns/1ps
module rore_chk #(parameter AW = 13) (
  // Inputs
  input wire          clock,
  input wire          sys_rst,
  input wire          instr_valid,
  input wire [2:0]    instr_op,
  input wire [7:0]    instr_imm,
  input wire          irq_pending,
  input wire [7:0]    mem_rdata,
  // Outputs
  input wire          mem_wr_r,
  input wire [7:0]    mem_wdata_r,
  input wire [7:0]    accumulator_r,
  input wire          zero_flag_r,
  input wire          master_irq_enable_r,
  input wire [AW-1:0] pc_r,
  input wire          pc_load_r,
  input wire          busy_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire go = instr_valid && !busy_r;
  // Read data is taken one cycle before the write strobe shows
  property p_or_mem; go && instr_op == 3'h1 |-> ##3 mem_wr_r &&
    mem_wdata_r == (accumulator_r | $past(mem_rdata)) &&
    zero_flag_r == (mem_wdata_r == 8'h00); endproperty
  a_or_mem: assert property (p_or_mem) else $error("or write");
  property p_return; go && instr_op == 3'h2 |-> ##2 pc_load_r &&
    zero_flag_r == $past(zero_flag_r, 2); endproperty
  a_return: assert property (p_return) else $error("return");
  property p_load_imm; go && instr_op == 3'h3 |=>
    accumulator_r == $past(instr_imm); endproperty
  a_load_imm: assert property (p_load_imm) else $error("imm load");
  property p_mie_set; go && instr_op == 3'h4 |=> master_irq_enable_r;
  endproperty
  a_mie_set: assert property (p_mie_set) else $error("enable");
  property p_vec; go && instr_op == 3'h4 && irq_pending ##1
    irq_pending |=> pc_load_r && pc_r == 4; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_rotate; go && instr_op == 3'h5 |-> ##3 mem_wr_r &&
    mem_wdata_r == {$past(mem_rdata[6:0]), $past(mem_rdata[7])};
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate");
  c_or_mem: cover property (go && instr_op == 3'h1);
  c_vec: cover property (go && instr_op == 3'h4 && irq_pending);
  c_rotate: cover property (go && instr_op == 3'h5);
endmodule
bind rore_exec rore_chk #(.AW(AW)) rore_chk_i (.clock(clock),
  .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_op(instr_op),
  .instr_imm(instr_imm), .irq_pending(irq_pending),
  .mem_rdata(mem_rdata), .mem_wr_r(mem_wr_r), .pc_r(pc_r),
  .mem_wdata_r(mem_wdata_r), .accumulator_r(accumulator_r),
  .zero_flag_r(zero_flag_r), .pc_load_r(pc_load_r), .busy_r(busy_r),
  .master_irq_enable_r(master_irq_enable_r));

// *** bench/rore_exec_bench.sv ***
// Directed bench for the exec block
`timescale 1ns/1ps
module rore_exec_bench;
  logic        clock, sys_rst, instr_valid, call_push, irq_pending;
  logic        mem_rd_r, mem_wr_r, zero_flag_r, mie, pc_load_r, busy_r;
  logic        irq_ack_r;
  logic [2:0]  instr_op;
  logic [7:0]  instr_imm, instr_addr, mem_rdata, mem_addr_r, wd, accum;
  logic [12:0] call_addr, pc_r;
  int          n_mismatch = 0, checked = 0;
  rore_exec rore_exec_i (.clock(clock), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_imm(instr_imm), .instr_addr(instr_addr),
    .call_push(call_push), .call_addr(call_addr),
    .irq_pending(irq_pending), .mem_addr_r(mem_addr_r),
    .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r), .mem_wdata_r(wd),
    .mem_rdata(mem_rdata), .accumulator_r(accum),
    .zero_flag_r(zero_flag_r), .master_irq_enable_r(mie),
    .pc_r(pc_r), .pc_load_r(pc_load_r), .busy_r(busy_r),
    .irq_ack_r(irq_ack_r));
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string s, logic [12:0] e, logic [12:0] g);
    checked++;
    if (e !== g) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic psh(logic [12:0] a);
    call_addr = a;
    call_push = 1;
    @(posedge clock);
    #1 call_push = 0;
  endtask
  // Runs one instruction; returns just after its final strobe
  task automatic run(logic [2:0] op, logic [7:0] im, rd, logic irq);
    int n;
    n = 0;
    {instr_op, instr_imm, irq_pending} = {op, im, irq};
    instr_valid = 1;
    @(posedge clock);
    #1 instr_valid = 0;
    mem_rdata = rd;
    chk("rd", op == 3'h1 || op == 3'h5, mem_rd_r);
    chk("busy", 1, busy_r);
    while (mem_wr_r !== 1 && pc_load_r !== 1) begin
      @(posedge clock);
      #1 n++;
      if (n > 8) begin
        chk("wait", 0, 1);
        finish_test;
      end
    end
    chk("idle", 0, busy_r);
    mem_rdata = ~rd;
  endtask
  task automatic t_or;
    psh(13'h0b2);
    run(3'h3, 8'h0f, 8'h00, 0);
    chk("pc", 13'h0b2, pc_r);
    chk("accumulator", 8'h0f, accum);
    run(3'h1, 8'h00, 8'h30, 0);
    chk("wd", 8'h3f, wd);
    chk("z", 0, zero_flag_r);
    chk("addr", 8'h5a, mem_addr_r);
    psh(13'h0001);
    run(3'h3, 8'h00, 8'h00, 0);
    run(3'h1, 8'h00, 8'h00, 0);
    chk("z", 1, zero_flag_r);
  endtask
  task automatic t_return;
    psh(13'h1a5);
    run(3'h2, 8'h00, 8'h00, 0);
    chk("pc", 13'h1a5, pc_r);
    chk("z", 1, zero_flag_r);
    psh(13'h0777);
    run(3'h4, 8'h00, 8'h00, 0);
    chk("pc", 13'h0777, pc_r);
    chk("mie", 1, mie);
    psh(13'h0123);
    run(3'h4, 8'h00, 8'h00, 1);
    chk("pc", 13'h0004, pc_r);
    chk("ack", 1, irq_ack_r);
    chk("mie", 0, mie);
    run(3'h4, 8'h00, 8'h00, 0);
    chk("pc", 13'h0123, pc_r);
    chk("mie", 1, mie);
  endtask
  task automatic t_rotate;
    run(3'h5, 8'h00, 8'h81, 0);
    chk("wd", 8'h03, wd);
    chk("z", 1, zero_flag_r);
  endtask
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial begin
    {instr_valid, call_push, irq_pending, instr_op} = 0;
    {instr_imm, mem_rdata, call_addr} = 0;
    instr_addr = 8'h5a;
    sys_rst = 1;
    repeat (10) @(posedge clock);
    #1 sys_rst = 0;
    t_or;
    t_return;
    t_rotate;
    finish_test;
  end
endmodule

// *** core/rore_exec.v ***
// Executes OR-to-memory, the three returns and rotate-left of memory
//
// Contract
// - OR accumulator into memory byte, update zero
// - Return pops stack into PC, flags untouched
// - Return-immediate pops PC and loads accumulator
// - Interrupt return pops PC, sets master enable
// - Pending interrupt at interrupt return is serviced first
// - Rotate memory byte left, bit 7 into 0
`timescale 1ns/1ps
`include "rore_map.vh"
module rore_exec #(
  parameter AW    = 13,
  parameter DEPTH = 8,
  parameter PW    = 3
) (
  // Clock and reset
  input  wire          clock,
  input  wire          sys_rst,
  // Decoded instruction
  input  wire          instr_valid,
  input  wire [2:0]    instr_op,
  input  wire [7:0]    instr_imm,
  input  wire [7:0]    instr_addr,
  // Subroutine entry pushes return address
  input  wire          call_push,
  input  wire [AW-1:0] call_addr,
  // Interrupt request level from the controller
  input  wire          irq_pending,
  // Data memory
  output reg  [7:0]    mem_addr_r,
  output reg           mem_rd_r,
  output reg           mem_wr_r,
  output reg  [7:0]    mem_wdata_r,
  input  wire [7:0]    mem_rdata,
  // Core state
  output reg  [7:0]    accumulator_r,
  output reg           zero_flag_r,
  output reg           master_irq_enable_r,
  output reg  [AW-1:0] pc_r,
  output reg           pc_load_r,
  output reg           busy_r,
  output reg           irq_ack_r
);
  // Which return is in flight, held for its final cycle
  localparam RK_PLAIN = 2'h0;
  localparam RK_IMM   = 2'h1;
  localparam RK_INT   = 2'h2;

  reg  [1:0]    state_r;
  reg  [2:0]    op_r;
  reg           pop_r;
  reg  [1:0]    rtn_kind_r;
  reg  [AW-1:0] rtn_addr_r;
  wire [AW-1:0] stack_top;

  // Opcode group decodes
  function is_return;
    input [2:0] op;
    begin
      is_return = (op == `RORE_OP_RETURN) ||
                  (op == `RORE_OP_RETURN_IMM) ||
                  (op == `RORE_OP_RETURN_INT);
    end
  endfunction

  function is_mem_op;
    input [2:0] op;
    begin
      is_mem_op = (op == `RORE_OP_OR_MEM) || (op == `RORE_OP_ROTATE);
    end
  endfunction

  function rore_zero;
    input [7:0] val;
    begin
      rore_zero = (val == 8'h00);
    end
  endfunction

  function [7:0] rore_alu;
    input [2:0] op;
    input [7:0] accum;
    input [7:0] data;
    begin
      if (op == `RORE_OP_ROTATE)
        rore_alu = {data[6:0], data[7]};
      else
        rore_alu = accum | data;
    end
  endfunction

  // An instruction is taken only while state_r is idle; state_r blocks the rest, busy_r only shows it
  wire          take     = instr_valid && (state_r == `RORE_ST_IDLE);
  wire          rtn      = take && is_return(instr_op);
  wire          vec_now  = (rtn_kind_r == RK_INT) && irq_pending;
  wire          fin      = (state_r == `RORE_ST_WRITE);
  // Read data is only meaningful in the write cycle
  wire [7:0]    alu_out  = rore_alu(op_r, accumulator_r, mem_rdata);
  // An interrupt return that vectors puts its address back, so the
  // handler's own return lands on the interrupted program
  wire          restack  = vec_now && pop_r;
  wire          stk_push = call_push || restack;
  wire [AW-1:0] stk_addr = call_push ? call_addr : rtn_addr_r;

  // A call push in the same cycle as a restack wins; callers must not
  // push while a return is still busy
  rore_stack #(.AW(AW), .DEPTH(DEPTH), .PW(PW)) rore_stack_i (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .push      (stk_push),
    .push_addr (stk_addr),
    .pop       (rtn),
    .top_r     (stack_top)
  );

  // The stack shows the entry below once its pointer steps back, so
  // the address being returned to is caught before the pop lands
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      rtn_addr_r <= {AW{1'b0}};
    else if (rtn)
      rtn_addr_r <= stack_top;
  end

  // Only the OR updates zero; rotate and the returns leave it alone
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      zero_flag_r <= 1'b0;
    else if (fin && op_r == `RORE_OP_OR_MEM)
      zero_flag_r <= rore_zero(alu_out);
  end

  // Set by the interrupt return, cleared again when it vectors at once
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      master_irq_enable_r <= 1'b0;
    else if (rtn && instr_op == `RORE_OP_RETURN_INT)
      master_irq_enable_r <= 1'b1;
    else if (fin && !is_mem_op(op_r) && vec_now)
      master_irq_enable_r <= 1'b0;
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r       <= `RORE_ST_IDLE;
      op_r          <= `RORE_OP_NOP;
      pop_r         <= 1'b0;
      rtn_kind_r    <= RK_PLAIN;
      mem_addr_r    <= 8'h00;
      mem_rd_r      <= 1'b0;
      mem_wr_r      <= 1'b0;
      mem_wdata_r   <= 8'h00;
      accumulator_r <= `RORE_ACC_RST;
      pc_r          <= `RORE_PC_RST;
      pc_load_r     <= 1'b0;
      busy_r        <= 1'b0;
      irq_ack_r     <= 1'b0;
    end else begin
      mem_rd_r  <= 1'b0;
      mem_wr_r  <= 1'b0;
      pc_load_r <= 1'b0;
      irq_ack_r <= 1'b0;
      pop_r     <= 1'b0;
      case (state_r)
        `RORE_ST_IDLE: begin
          if (instr_valid) begin
            op_r <= instr_op;
            case (instr_op)
              `RORE_OP_OR_MEM, `RORE_OP_ROTATE: begin
                mem_addr_r <= instr_addr;
                mem_rd_r   <= 1'b1;
                busy_r     <= 1'b1;
                state_r    <= `RORE_ST_READ;
              end
              `RORE_OP_RETURN: begin
                pop_r      <= 1'b1;
                rtn_kind_r <= RK_PLAIN;
                busy_r     <= 1'b1;
                state_r    <= `RORE_ST_WRITE;
              end
              `RORE_OP_RETURN_IMM: begin
                accumulator_r <= instr_imm;
                pop_r         <= 1'b1;
                rtn_kind_r    <= RK_IMM;
                busy_r        <= 1'b1;
                state_r       <= `RORE_ST_WRITE;
              end
              `RORE_OP_RETURN_INT: begin
                pop_r      <= 1'b1;
                rtn_kind_r <= RK_INT;
                busy_r     <= 1'b1;
                state_r    <= `RORE_ST_WRITE;
              end
              default: begin
                busy_r <= 1'b0;
              end
            endcase
          end
        end
        `RORE_ST_READ: begin
          // Data memory answers one cycle after the read strobe
          state_r <= `RORE_ST_WRITE;
        end
        `RORE_ST_WRITE: begin
          busy_r  <= 1'b0;
          state_r <= `RORE_ST_IDLE;
          if (is_mem_op(op_r)) begin
            mem_wdata_r <= alu_out;
            mem_wr_r    <= 1'b1;
          end else if (vec_now) begin
            // Return address stays stacked so the handler returns to it
            pc_r      <= `RORE_VEC_RST;
            pc_load_r <= 1'b1;
            irq_ack_r <= 1'b1;
          end else begin
            pc_r      <= rtn_addr_r;
            pc_load_r <= 1'b1;
          end
        end
        default: begin
          state_r <= `RORE_ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end
endmodule

// *** core/rore_map.vh ***
// Opcode codes, state codes and reset values for the exec block
`ifndef RORE_MAP_VH
`define RORE_MAP_VH
`define RORE_OP_NOP       3'h0
`define RORE_OP_OR_MEM     3'h1
`define RORE_OP_RETURN     3'h2
`define RORE_OP_RETURN_IMM 3'h3
`define RORE_OP_RETURN_INT 3'h4
`define RORE_OP_ROTATE     3'h5
`define RORE_ACC_RST      8'h00
`define RORE_PC_RST       13'h0000
`define RORE_VEC_RST      13'h0004
`define RORE_ST_IDLE      2'h0
`define RORE_ST_READ      2'h1
`define RORE_ST_WRITE     2'h2
`endif

// *** core/rore_stack.v ***
// Return address stack with registered read data
`timescale 1ns/1ps
module rore_stack #(
  parameter AW    = 13,
  parameter DEPTH = 8,
  parameter PW    = 3
) (
  // Clock and reset
  input  wire          clock,
  input  wire          sys_rst,
  // Push and pop
  input  wire          push,
  input  wire [AW-1:0] push_addr,
  input  wire          pop,
  output reg  [AW-1:0] top_r
);
  reg [AW-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] ptr_r;
  wire [PW-1:0] below = ptr_r - {{(PW-1){1'b0}}, 1'b1};

  always @(posedge clock) begin
    if (push)
      mem[ptr_r] <= push_addr;
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_r <= {PW{1'b0}};
      top_r <= {AW{1'b0}};
    end else if (push) begin
      ptr_r <= ptr_r + {{(PW-1){1'b0}}, 1'b1};
      top_r <= push_addr;
    end else if (pop) begin
      // Wraps on underflow, like a circular hardware stack
      ptr_r <= below;
      top_r <= mem[below - {{(PW-1){1'b0}}, 1'b1}];
    end
  end
endmodule
